/* File: core/fpc_consts.vh */
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH

// ----------------------------------------
// Operating modes at reset release
// ----------------------------------------
`define FPC_MODE_NORMAL   2'h0
`define FPC_MODE_PROGRAM  2'h1
`define FPC_MODE_PROHIBIT 2'h2

// ----------------------------------------
// Channel selection
// ----------------------------------------
`define FPC_PULSE_MAX     4'hB
`define FPC_CH_NONE       2'h0
`define FPC_CH_ASYNC      2'h1
`define FPC_CH_CLOCKED    2'h2
`define FPC_CH_CLOCKED_HS 2'h3
`define FPC_PULSES_ASYNC  4'h0
`define FPC_PULSES_CSI    4'h8
`define FPC_PULSES_CSI_HS 4'h9
`define FPC_SEL_WAIT_NS   2000000
`define FPC_CLK_NS        50
`define FPC_SEL_WAIT_CYC  ((`FPC_SEL_WAIT_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)

// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define FPC_OP_RESET      8'h00
`define FPC_OP_BLANK      8'h32
`define FPC_OP_CHIP_ERASE 8'h20
`define FPC_OP_BLK_ERASE  8'h22
`define FPC_OP_PROGRAM    8'h40
`define FPC_OP_VERIFY     8'h13
`define FPC_OP_CHECKSUM   8'hB0
`define FPC_OP_SIGNATURE  8'hC0
`define FPC_OP_SECURITY   8'hA0

// ----------------------------------------
// Response status codes
// ----------------------------------------
`define FPC_ST_ACK        8'h06
`define FPC_ST_NACK       8'h15
`define FPC_ST_PROTECT    8'h10
`define FPC_ST_MISMATCH   8'h1B

// ----------------------------------------
// Flash geometry
// ----------------------------------------
`define FPC_ADDR_W        8
`define FPC_BLK_SHIFT     4
`define FPC_ERASED        8'hFF
`define FPC_SIG_DEFAULT   8'h5A

`endif

/* File: core/fpc_sync.v */
`timescale 1ns/100ps
module fpc_sync (
  input  wire clock,
  input  wire rst,
  input  wire din,
  output wire dout
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge clock) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule // fpc_sync

/* File: core/fpc_link.v */
`timescale 1ns/100ps
`include "fpc_consts.vh"
// Byte link: async (baud learned from reset byte) or clocked slave.
module fpc_link (
  input  wire       clock,
  input  wire       rst,
  input  wire [1:0] channel,
  input  wire       rx_s,
  input  wire       sck_s,
  output reg  [7:0] rx_data,
  output reg        rx_valid,
  input  wire [7:0] tx_data,
  input  wire       tx_start,
  output wire       tx_busy,
  output reg        tx_line,
  output reg        so_line
);
  reg [15:0] bit_len_reg;
  reg        baud_ok_reg;
  reg [15:0] cnt_reg;
  reg [3:0]  rbit_reg;
  reg [7:0]  rsh_reg;
  reg        ract_reg;
  reg        rx_d_reg;
  reg        sck_d_reg;
  reg [3:0]  tbit_reg;
  reg [15:0] tcnt_reg;
  reg [9:0]  tsh_reg;
  reg        tact_reg;
  wire       is_async = (channel == `FPC_CH_ASYNC);
  wire       sck_rise = sck_s & ~sck_d_reg;
  wire       sck_fall = ~sck_s & sck_d_reg;

  assign tx_busy = tact_reg;

  // ----------------------------------------
  // Receive
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      bit_len_reg <= 16'h0000; baud_ok_reg <= 1'b0; cnt_reg <= 16'h0000;
      rbit_reg <= 4'h0; rsh_reg <= 8'h00; ract_reg <= 1'b0;
      rx_d_reg <= 1'b1; sck_d_reg <= 1'b0; rx_data <= 8'h00; rx_valid <= 1'b0;
    end else begin
      rx_d_reg  <= rx_s;
      sck_d_reg <= sck_s;
      rx_valid  <= 1'b0;
      if (is_async && !baud_ok_reg) begin
        // Reset byte 0x00 gives a 9-bit low span: measure it for the baud
        if (!rx_s)
          cnt_reg <= cnt_reg + 16'h0001;
        else if (!rx_d_reg && cnt_reg != 16'h0000) begin
          bit_len_reg <= cnt_reg / 16'h0009;
          baud_ok_reg <= 1'b1;
          cnt_reg     <= 16'h0000;
          rx_data     <= `FPC_OP_RESET;
          rx_valid    <= 1'b1;
        end
      end else if (is_async) begin
        if (!ract_reg && rx_d_reg && !rx_s) begin
          ract_reg <= 1'b1;
          cnt_reg  <= bit_len_reg + (bit_len_reg >> 1);
          rbit_reg <= 4'h0;
        end else if (ract_reg) begin
          if (cnt_reg == 16'h0000) begin
            cnt_reg <= bit_len_reg;
            if (rbit_reg == 4'h8) begin
              ract_reg <= 1'b0;
              rx_data  <= rsh_reg;
              rx_valid <= 1'b1;
            end else begin
              rsh_reg  <= {rx_s, rsh_reg[7:1]};
              rbit_reg <= rbit_reg + 4'h1;
              if (rbit_reg == 4'h7) cnt_reg <= bit_len_reg >> 1;
            end
          end else
            cnt_reg <= cnt_reg - 16'h0001;
        end
      end else if (channel != `FPC_CH_NONE && sck_rise) begin
        // Clocked slave, MSB first, sample on rising edge
        rsh_reg <= {rsh_reg[6:0], rx_s};
        if (rbit_reg == 4'h7) begin
          rbit_reg <= 4'h0;
          rx_data  <= {rsh_reg[6:0], rx_s};
          rx_valid <= 1'b1;
        end else
          rbit_reg <= rbit_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Transmit
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      tbit_reg <= 4'h0; tcnt_reg <= 16'h0000; tsh_reg <= 10'h3FF;
      tact_reg <= 1'b0; tx_line <= 1'b1; so_line <= 1'b1;
    end else if (tx_start && !tact_reg) begin
      tact_reg <= 1'b1;
      tbit_reg <= 4'h0;
      tcnt_reg <= bit_len_reg;
      tsh_reg  <= {1'b1, tx_data, 1'b0};
      if (is_async) tx_line <= 1'b0;
      else so_line <= tx_data[7];
    end else if (tact_reg && is_async) begin
      if (tcnt_reg == 16'h0000) begin
        tcnt_reg <= bit_len_reg;
        tsh_reg  <= {1'b1, tsh_reg[9:1]};
        tx_line  <= tsh_reg[1];
        tbit_reg <= tbit_reg + 4'h1;
        if (tbit_reg == 4'h9) begin tact_reg <= 1'b0; tx_line <= 1'b1; end
      end else
        tcnt_reg <= tcnt_reg - 16'h0001;
    end else if (tact_reg && sck_fall) begin
      // First fall repeats bit 7 so the master samples all eight bits
      tbit_reg <= tbit_reg + 4'h1;
      so_line  <= tsh_reg[8];
      tsh_reg  <= {tsh_reg[8:0], 1'b1};
    end else if (tact_reg && sck_rise && tbit_reg == 4'h8) begin
      tact_reg <= 1'b0;
      so_line  <= 1'b1;
    end
  end
endmodule // fpc_link

/* File: core/fpc_port.v */
`timescale 1ns/100ps
`include "fpc_consts.vh"
module fpc_port #(
  parameter [7:0]  SIGNATURE    = `FPC_SIG_DEFAULT, // Arbitrary value
  parameter [31:0] SEL_WAIT_CYC = `FPC_SEL_WAIT_CYC
) (
  input  wire       clock,
  input  wire       rst,
  input  wire       mode_select_pin_a,
  input  wire       mode_select_pin_b,
  input  wire       async_receive_line,
  output wire       async_transmit_line,
  input  wire       clocked_serial_in,
  output wire       clocked_serial_out,
  input  wire       clocked_serial_clock,
  output wire       handshake_port_line,
  output wire       handshake_port_line_oe,
  input  wire       self_write_req,
  input  wire [7:0] self_write_addr,
  input  wire [7:0] self_write_data,
  output reg        self_write_done,
  output reg  [1:0] op_mode,
  output reg  [1:0] channel,
  output wire       hold_reset_pins
);
  localparam S_START  = 8'h01;
  localparam S_PULSE  = 8'h02;
  localparam S_IDLE   = 8'h04;
  localparam S_ARGS   = 8'h08;
  localparam S_EXEC   = 8'h10;
  localparam S_DATA   = 8'h20;
  localparam S_RESP   = 8'h40;
  localparam S_RUN    = 8'h80;

  wire       pin_a_s;
  wire       pin_b_s;
  wire       rx_s;
  wire       sck_s;
  wire [7:0] rx_data;
  wire       rx_valid;
  wire       tx_busy;
  wire       tx_line;
  wire       so_line;

  reg [7:0]  mem [0:255];
  reg [7:0]  state_reg;
  reg        pin_a_d_reg;
  reg [3:0]  pulses_reg;
  reg [31:0] wait_reg;
  reg        secured_reg;
  reg [7:0]  op_reg;
  reg [7:0]  lo_reg;
  reg [7:0]  hi_reg;
  reg [7:0]  ptr_reg;
  reg [1:0]  argn_reg;
  reg [7:0]  status_reg;
  reg [7:0]  result_reg;
  reg [7:0]  sum_reg;
  reg [7:0]  tx_data_reg;
  reg        tx_start_reg;
  reg        rsp2_reg;
  reg        ok_reg;
  reg        chk_reg;

  fpc_sync u_sync_a   (.clock(clock), .rst(rst), .din(mode_select_pin_a),    .dout(pin_a_s));
  fpc_sync u_sync_b   (.clock(clock), .rst(rst), .din(mode_select_pin_b),    .dout(pin_b_s));
  fpc_sync u_sync_rx  (.clock(clock), .rst(rst),
                       .din(channel == `FPC_CH_ASYNC ? async_receive_line : clocked_serial_in),
                       .dout(rx_s));
  fpc_sync u_sync_sck (.clock(clock), .rst(rst), .din(clocked_serial_clock), .dout(sck_s));

  fpc_link u_link (
    .clock    (clock),
    .rst      (rst),
    .channel  (channel),
    .rx_s     (rx_s),
    .sck_s    (sck_s),
    .rx_data  (rx_data),
    .rx_valid (rx_valid),
    .tx_data  (tx_data_reg),
    .tx_start (tx_start_reg),
    .tx_busy  (tx_busy),
    .tx_line  (tx_line),
    .so_line  (so_line)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [1:0] chan_of;
    input [3:0] n;
    begin
      if (n == `FPC_PULSES_ASYNC)       chan_of = `FPC_CH_ASYNC;
      else if (n == `FPC_PULSES_CSI)    chan_of = `FPC_CH_CLOCKED;
      else if (n == `FPC_PULSES_CSI_HS) chan_of = `FPC_CH_CLOCKED_HS;
      else                              chan_of = `FPC_CH_NONE;
    end
  endfunction

  function needs_args;
    input [7:0] op;
    begin
      needs_args = (op == `FPC_OP_BLANK) || (op == `FPC_OP_BLK_ERASE) ||
                   (op == `FPC_OP_PROGRAM) || (op == `FPC_OP_VERIFY) ||
                   (op == `FPC_OP_CHECKSUM);
    end
  endfunction

  function is_boot;
    input [7:0] a;
    begin
      is_boot = (a[7:`FPC_BLK_SHIFT] == 4'h0);
    end
  endfunction

  // only the selected channel's lines are driven, idle high
  assign async_transmit_line    = (channel == `FPC_CH_ASYNC) ? tx_line : 1'b1;
  assign clocked_serial_out     = (channel[1]) ? so_line : 1'b1;
  // Ready also while a response waits for the master's clock
  assign handshake_port_line    = tx_busy || (state_reg == S_IDLE || state_reg == S_ARGS ||
                                              state_reg == S_DATA);
  assign handshake_port_line_oe = (channel == `FPC_CH_CLOCKED_HS);
  assign hold_reset_pins        = (op_mode == `FPC_MODE_PROGRAM);

  // ----------------------------------------
  // Mode entry and command engine
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      state_reg <= S_START; op_mode <= `FPC_MODE_NORMAL; channel <= `FPC_CH_NONE;
      pin_a_d_reg <= 1'b0; pulses_reg <= 4'h0; wait_reg <= 32'h0;
      op_reg <= 8'h00; lo_reg <= 8'h00; hi_reg <= 8'h00; ptr_reg <= 8'h00;
      argn_reg <= 2'h0; status_reg <= 8'h00; result_reg <= 8'h00; sum_reg <= 8'h00;
      tx_data_reg <= 8'h00; tx_start_reg <= 1'b0; rsp2_reg <= 1'b0; ok_reg <= 1'b1;
      self_write_done <= 1'b0;
      secured_reg <= 1'b0;
      chk_reg <= 1'b0;
    end else begin
      tx_start_reg    <= 1'b0;
      self_write_done <= 1'b0;
      pin_a_d_reg     <= pin_a_s;
      chk_reg         <= 1'b0;
      // Read-back of the cell written on the previous edge
      if (chk_reg && mem[ptr_reg - 8'h01] != result_reg) ok_reg <= 1'b0;
      case (state_reg)
        S_START: begin
          // Sync delay lets pins settle after release
          if (wait_reg == 32'h2) begin
            if (!pin_a_s) begin
              op_mode <= `FPC_MODE_NORMAL; state_reg <= S_RUN;
            end else if (!pin_b_s) begin
              op_mode <= `FPC_MODE_PROGRAM; state_reg <= S_PULSE;
            end else begin
              op_mode <= `FPC_MODE_PROHIBIT; state_reg <= S_RUN;
            end
            wait_reg <= 32'h0;
          end else
            wait_reg <= wait_reg + 32'h1;
        end
        S_PULSE: begin
          if (pin_a_s && !pin_a_d_reg) begin
            wait_reg <= 32'h0;
            if (pulses_reg != `FPC_PULSE_MAX) pulses_reg <= pulses_reg + 4'h1;
          end else if (wait_reg >= SEL_WAIT_CYC - 32'h1) begin
            channel   <= chan_of(pulses_reg);
            state_reg <= (chan_of(pulses_reg) == `FPC_CH_NONE) ? S_RUN : S_IDLE;
          end else
            wait_reg <= wait_reg + 32'h1;
        end
        S_IDLE: begin
          if (rx_valid) begin
            op_reg <= rx_data; argn_reg <= 2'h0; ok_reg <= 1'b1; sum_reg <= 8'h00;
            ptr_reg <= 8'h00;
            state_reg <= needs_args(rx_data) ? S_ARGS : S_EXEC;
          end
        end
        S_ARGS: begin
          if (rx_valid) begin
            argn_reg <= argn_reg + 2'h1;
            if (argn_reg == 2'h0) lo_reg <= rx_data;
            else begin
              hi_reg  <= rx_data;
              ptr_reg <= lo_reg;
              state_reg <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          result_reg <= 8'h00; rsp2_reg <= 1'b0; status_reg <= `FPC_ST_ACK;
          state_reg  <= S_RESP;
          case (op_reg)
            `FPC_OP_RESET, `FPC_OP_SECURITY: begin
              if (op_reg == `FPC_OP_SECURITY) secured_reg <= 1'b1;
            end
            `FPC_OP_BLANK: begin
              if (mem[ptr_reg] != `FPC_ERASED) ok_reg <= 1'b0;
              if (ptr_reg != hi_reg) begin
                ptr_reg <= ptr_reg + 8'h01; state_reg <= S_EXEC;
              end else if (!ok_reg || mem[ptr_reg] != `FPC_ERASED)
                status_reg <= `FPC_ST_MISMATCH;
            end
            `FPC_OP_CHIP_ERASE, `FPC_OP_BLK_ERASE: begin
              if (secured_reg) status_reg <= `FPC_ST_PROTECT;
              else begin
                mem[ptr_reg] <= `FPC_ERASED;
                if (op_reg == `FPC_OP_CHIP_ERASE ? ptr_reg != 8'hFF : ptr_reg != hi_reg) begin
                  ptr_reg <= ptr_reg + 8'h01; state_reg <= S_EXEC;
                end
              end
            end
            `FPC_OP_PROGRAM, `FPC_OP_VERIFY: begin
              if (op_reg == `FPC_OP_PROGRAM && (secured_reg || is_boot(lo_reg)))
                status_reg <= `FPC_ST_PROTECT;
              else state_reg <= S_DATA;
            end
            `FPC_OP_CHECKSUM: begin
              if (secured_reg) status_reg <= `FPC_ST_PROTECT;
              else begin
                sum_reg <= sum_reg + mem[ptr_reg];
                result_reg <= sum_reg + mem[ptr_reg]; rsp2_reg <= 1'b1;
                if (ptr_reg != hi_reg) begin
                  ptr_reg <= ptr_reg + 8'h01; state_reg <= S_EXEC;
                end
              end
            end
            `FPC_OP_SIGNATURE: begin
              result_reg <= SIGNATURE; rsp2_reg <= 1'b1;
            end
            default: status_reg <= `FPC_ST_NACK;
          endcase
        end
        S_DATA: begin
          if (rx_valid) begin
            // Program writes then reads back; verify only compares
            if (op_reg == `FPC_OP_PROGRAM) begin
              mem[ptr_reg] <= rx_data;
              result_reg <= rx_data;
              chk_reg <= 1'b1;
            end else if (mem[ptr_reg] != rx_data) ok_reg <= 1'b0;
            ptr_reg <= ptr_reg + 8'h01;
            if (ptr_reg == hi_reg) begin
              // Last read-back settles during one plain pass through execute
              if (op_reg == `FPC_OP_PROGRAM) begin
                op_reg <= `FPC_OP_RESET;
                state_reg <= S_EXEC;
              end else begin
                status_reg <= `FPC_ST_ACK;
                state_reg  <= S_RESP;
              end
            end
          end
        end
        S_RESP: begin
          if (!tx_busy && !tx_start_reg) begin
            tx_start_reg <= 1'b1;
            if (ok_reg || status_reg != `FPC_ST_ACK) tx_data_reg <= status_reg;
            else tx_data_reg <= `FPC_ST_MISMATCH;
            if (rsp2_reg) begin
              status_reg <= result_reg; ok_reg <= 1'b1; rsp2_reg <= 1'b0;
            end else state_reg <= S_IDLE;
          end
        end
        S_RUN: begin
          // Self programming: write only with pin A high
          if (self_write_req && pin_a_s && op_mode == `FPC_MODE_NORMAL) begin
            mem[self_write_addr] <= self_write_data;
            self_write_done <= 1'b1;
          end
        end
        default: state_reg <= S_START;
      endcase
    end
  end

endmodule // fpc_port

/* File: dv/fpc_port_monitor.sv */
`timescale 1ns/100ps
`include "fpc_consts.vh"
module fpc_port_monitor #(
  parameter [31:0] SEL_WAIT_CYC = `FPC_SEL_WAIT_CYC
) (
  input wire       clock,
  input wire       rst,
  input wire       mode_select_pin_a,
  input wire       mode_select_pin_b,
  input wire       async_transmit_line,
  input wire       clocked_serial_out,
  input wire       handshake_port_line_oe,
  input wire       self_write_done,
  input wire [1:0] op_mode,
  input wire [1:0] channel,
  input wire       hold_reset_pins
);
  // ----------------------------------------
  // Cycles since last pin A rise
  // ----------------------------------------
  reg [31:0] quiet_reg;
  reg        pin_a_d_reg;
  always @(posedge clock) begin
    pin_a_d_reg <= mode_select_pin_a;
    if (rst || (mode_select_pin_a && !pin_a_d_reg)) begin
      quiet_reg <= 32'h0;
    end else if (quiet_reg != 32'hFFFFFFFF) begin
      quiet_reg <= quiet_reg + 32'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_normal;
    $fell(rst) && !mode_select_pin_a |-> ##[1:8] op_mode == `FPC_MODE_NORMAL;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode not entered");
  property p_prog;
    $fell(rst) && mode_select_pin_a && !mode_select_pin_b
      |-> ##[1:8] op_mode == `FPC_MODE_PROGRAM;
  endproperty
  a_prog: assert property (p_prog) else $error("program mode not entered");
  property p_prohib;
    $fell(rst) && mode_select_pin_a && mode_select_pin_b
      |-> ##[1:8] op_mode == `FPC_MODE_PROHIBIT;
  endproperty
  a_prohib: assert property (p_prohib) else $error("prohibited pins accepted");
  property p_hold;
    (op_mode == `FPC_MODE_PROGRAM) [*3] |-> hold_reset_pins;
  endproperty
  a_hold: assert property (p_hold) else $error("pins not held in program mode");
  property p_sel;
    !$stable(channel) && channel != `FPC_CH_NONE
      |-> quiet_reg >= SEL_WAIT_CYC && quiet_reg <= SEL_WAIT_CYC + 32'd16;
  endproperty
  a_sel: assert property (p_sel) else $error("channel chosen at wrong time");
  property p_selprog;
    !$stable(channel) && channel != `FPC_CH_NONE |-> op_mode == `FPC_MODE_PROGRAM;
  endproperty
  a_selprog: assert property (p_selprog) else $error("channel set outside program");
  property p_hs_oe;
    $stable(channel) |-> handshake_port_line_oe == (channel == `FPC_CH_CLOCKED_HS);
  endproperty
  a_hs_oe: assert property (p_hs_oe) else $error("handshake enable wrong");
  property p_lines;
    $stable(channel) |-> (channel == `FPC_CH_ASYNC || async_transmit_line) &&
                         (channel[1] || clocked_serial_out);
  endproperty
  a_lines: assert property (p_lines) else $error("unused transmit line active");
  property p_self;
    self_write_done |-> $past(mode_select_pin_a, 3) && op_mode == `FPC_MODE_NORMAL;
  endproperty
  a_self: assert property (p_self) else $error("self write without protect high");
  c_async: cover property (channel == `FPC_CH_ASYNC);
  c_hs: cover property (channel == `FPC_CH_CLOCKED_HS);
  c_self: cover property (self_write_done);
  c_prohib: cover property (op_mode == `FPC_MODE_PROHIBIT);
endmodule // fpc_port_monitor

/* File: dv/fpc_prog_model.sv */
`timescale 1ns/100ps
module fpc_prog_model (
  input  wire clock,
  input  wire sdi,
  input  wire hs,
  input  wire hs_oe,
  output reg  pin_a,
  output reg  pin_b,
  output reg  sck,
  output reg  sdo,
  output reg  rxd
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    sck = 1'b1;
    sdo = 1'b1;
    rxd = 1'b1;
  end
  // ----------------------------------------
  // Mode pins and select pulses
  // ----------------------------------------
  task set_pins(input a, input b);
    begin
      pin_a <= a;
      pin_b <= b;
    end
  endtask
  task pulses(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        repeat (4) @(posedge clock);
        pin_a <= 1'b0;
        repeat (4) @(posedge clock);
        pin_a <= 1'b1;
      end
    end
  endtask
  // ----------------------------------------
  // Clocked byte, MSB first, we own the clock
  // ----------------------------------------
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    integer w;
    begin
      w = 0;
      while (hs_oe && !hs && w < 400) begin
        @(posedge clock);
        w = w + 1;
      end
      for (i = 7; i >= 0; i = i - 1) begin
        @(posedge clock);
        sck <= 1'b0;
        sdo <= tx[i];
        repeat (3) @(posedge clock);
        @(negedge clock);
        rx[i] = sdi;
        @(posedge clock);
        sck <= 1'b1;
        repeat (3) @(posedge clock);
      end
      @(posedge clock);
      // Released line must not look like held data
      sdo <= ~tx[0];
      repeat (40) @(posedge clock);
    end
  endtask
endmodule // fpc_prog_model

/* File: dv/test_flash_program_mode_command_port.sv */
`timescale 1ns/100ps
`include "fpc_consts.vh"
module test_flash_program_mode_command_port;
  reg         clock;
  reg         rst;
  reg         self_write_req;
  reg  [7:0]  self_write_addr;
  reg  [7:0]  self_write_data;
  wire        pin_a, pin_b, rxd, txd, sdi, sdo, sck, hs, hs_oe, done, hold;
  wire [1:0]  op_mode;
  wire [1:0]  channel;
  integer     failures, cmp_count, seed, i, r, sum;
  integer     mem [0:255];
  reg  [7:0]  dbuf [0:3];
  reg  [7:0]  rx;
  fpc_port #(.SIGNATURE(8'h3C), .SEL_WAIT_CYC(32'd50)) uut (
    .clock(clock), .rst(rst), .mode_select_pin_a(pin_a), .mode_select_pin_b(pin_b),
    .async_receive_line(rxd), .async_transmit_line(txd), .clocked_serial_in(sdi),
    .clocked_serial_out(sdo), .clocked_serial_clock(sck), .handshake_port_line(hs),
    .handshake_port_line_oe(hs_oe), .self_write_req(self_write_req),
    .self_write_addr(self_write_addr), .self_write_data(self_write_data),
    .self_write_done(done), .op_mode(op_mode), .channel(channel), .hold_reset_pins(hold));
  fpc_prog_model prog (.clock(clock), .sdi(sdo), .hs(hs), .hs_oe(hs_oe), .pin_a(pin_a),
    .pin_b(pin_b), .sck(sck), .sdo(sdi), .rxd(rxd));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task check(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("Comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    failures = failures + 1;
    give_verdict;
  end
  // ----------------------------------------
  // Stimulus tasks
  // ----------------------------------------
  task do_reset(input a, input b);
    begin
      @(posedge clock);
      prog.set_pins(a, b);
      rst <= 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      repeat (12) @(posedge clock);
      @(negedge clock);
    end
  endtask
  task enter(input integer n, input [1:0] ch);
    begin
      do_reset(1'b1, 1'b0);
      check({6'h0, op_mode}, {6'h0, `FPC_MODE_PROGRAM});
      prog.pulses(n);
      repeat (80) @(posedge clock);
      @(negedge clock);
      check({6'h0, channel}, {6'h0, ch});
      check({7'h0, hs_oe}, {7'h0, ch == `FPC_CH_CLOCKED_HS});
      check({7'h0, hs & hs_oe}, {7'h0, ch == `FPC_CH_CLOCKED_HS});
    end
  endtask
  task self_wr(input a, input exp);
    integer k;
    reg got;
    begin
      @(posedge clock);
      prog.set_pins(a, 1'b0);
      repeat (6) @(posedge clock);
      r = $random(seed);
      self_write_addr <= r[7:0];
      self_write_data <= r[15:8];
      self_write_req <= 1'b1;
      got = 1'b0;
      for (k = 0; k < 20; k = k + 1) begin
        @(negedge clock);
        if (done === 1'b1) got = 1'b1;
      end
      @(posedge clock);
      self_write_req <= 1'b0;
      check({7'h0, got}, {7'h0, exp});
    end
  endtask
  // Only the checksum check leans on mem mirroring the array
  task cmd(input [7:0] op, input na, input [7:0] lo, input [7:0] hi, input integer nd,
           input [7:0] st, input nx, input [7:0] ex);
    integer k;
    begin
      prog.xfer(op, rx);
      if (na) begin
        prog.xfer(lo, rx);
        prog.xfer(hi, rx);
      end
      for (k = 0; k < nd; k = k + 1) prog.xfer(dbuf[k], rx);
      // Without handshake, outlast a full chip erase before reading
      repeat (300) @(posedge clock);
      prog.xfer(8'hFF, rx);
      check(rx, st);
      if (nx) begin
        prog.xfer(8'hFF, rx);
        check(rx, ex);
      end
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    self_write_req = 1'b0;
    self_write_addr = 8'h00;
    self_write_data = 8'h00;
    failures = 0;
    cmp_count = 0;
    seed = 32'he7501510;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    do_reset(1'b1, 1'b1);
    check({6'h0, op_mode}, {6'h0, `FPC_MODE_PROHIBIT});
    do_reset(1'b0, 1'b1);
    check({6'h0, op_mode}, {6'h0, `FPC_MODE_NORMAL});
    do_reset(1'b0, 1'b0);
    check({6'h0, op_mode}, {6'h0, `FPC_MODE_NORMAL});
    check({7'h0, hold}, 8'h00);
    self_wr(1'b1, 1'b1);
    self_wr(1'b0, 1'b0);
    enter(0, `FPC_CH_ASYNC);
    check({7'h0, sdo}, 8'h01);
    enter(9, `FPC_CH_CLOCKED_HS);
    cmd(`FPC_OP_SIGNATURE, 0, 8'h00, 8'h00, 0, `FPC_ST_ACK, 1, 8'h3C);
    enter(8, `FPC_CH_CLOCKED);
    check({7'h0, hold}, 8'h01);
    for (i = 0; i < 256; i = i + 1) mem[i] = 255;
    cmd(`FPC_OP_CHIP_ERASE, 0, 8'h00, 8'h00, 0, `FPC_ST_ACK, 0, 8'h00);
    cmd(`FPC_OP_BLANK, 1, 8'h00, 8'h0F, 0, `FPC_ST_ACK, 0, 8'h00);
    sum = 0;
    for (i = 0; i < 4; i = i + 1) begin
      r = $random(seed);
      dbuf[i] = r[7:0];
      mem[16 + i] = r[7:0];
      sum = sum + mem[16 + i];
    end
    cmd(`FPC_OP_PROGRAM, 1, 8'h10, 8'h13, 4, `FPC_ST_ACK, 0, 8'h00);
    cmd(`FPC_OP_VERIFY, 1, 8'h10, 8'h13, 4, `FPC_ST_ACK, 0, 8'h00);
    dbuf[2] = ~dbuf[2];
    cmd(`FPC_OP_VERIFY, 1, 8'h10, 8'h13, 4, `FPC_ST_MISMATCH, 0, 8'h00);
    cmd(`FPC_OP_CHECKSUM, 1, 8'h10, 8'h13, 0, `FPC_ST_ACK, 1, sum[7:0]);
    for (i = 16; i < 32; i = i + 1) mem[i] = 255;
    cmd(`FPC_OP_BLK_ERASE, 1, 8'h10, 8'h1F, 0, `FPC_ST_ACK, 0, 8'h00);
    cmd(`FPC_OP_BLANK, 1, 8'h10, 8'h1F, 0, `FPC_ST_ACK, 0, 8'h00);
    cmd(8'h77, 0, 8'h00, 8'h00, 0, `FPC_ST_NACK, 0, 8'h00);
    cmd(`FPC_OP_SECURITY, 0, 8'h00, 8'h00, 0, `FPC_ST_ACK, 0, 8'h00);
    cmd(`FPC_OP_CHIP_ERASE, 0, 8'h00, 8'h00, 0, `FPC_ST_PROTECT, 0, 8'h00);
    cmd(`FPC_OP_BLK_ERASE, 1, 8'h10, 8'h1F, 0, `FPC_ST_PROTECT, 0, 8'h00);
    cmd(`FPC_OP_CHECKSUM, 1, 8'h10, 8'h13, 0, `FPC_ST_PROTECT, 0, 8'h00);
    give_verdict;
  end
endmodule // test_flash_program_mode_command_port
bind fpc_port fpc_port_monitor #(.SEL_WAIT_CYC(SEL_WAIT_CYC)) mon (
  .clock(clock), .rst(rst), .mode_select_pin_a(mode_select_pin_a),
  .mode_select_pin_b(mode_select_pin_b), .async_transmit_line(async_transmit_line),
  .clocked_serial_out(clocked_serial_out), .handshake_port_line_oe(handshake_port_line_oe),
  .self_write_done(self_write_done), .op_mode(op_mode), .channel(channel),
  .hold_reset_pins(hold_reset_pins));
